// ---- core/lcdmd_cfg.svh ----
`ifndef LCDMD_CFG_SVH
`define LCDMD_CFG_SVH

// ==========================================
// Main table opcodes (7-bit prefixes, bit 0 is the data bit, unless full byte)
`define LCDMD_OP_DISP_PFX   7'h57
`define LCDMD_OP_INV_PFX    7'h53
`define LCDMD_OP_STAT_PFX   7'h52
`define LCDMD_OP_RESET      8'hE2
`define LCDMD_OP_SUB_ENTER  8'h70

// ==========================================
// Sub table opcodes (upper nibble unless full byte)
`define LCDMD_SUB_B1_START  4'h0
`define LCDMD_SUB_B1_COUNT  4'h1
`define LCDMD_SUB_B2_START  4'h2
`define LCDMD_SUB_B2_COUNT  4'h3
`define LCDMD_SUB_PART_EXEC 8'h40
`define LCDMD_SUB_NL_HI     4'h5
`define LCDMD_SUB_NL_LO     4'h6
`define LCDMD_SUB_NL_EXEC   8'h70
`define LCDMD_SUB_EXIT      8'h71

// ==========================================
// Geometry and reset values
`define LCDMD_UNITS         4'hD
`define LCDMD_UNIT_SHIFT    3
`define LCDMD_FULL_LINES    7'h68
`define LCDMD_RST_B1_START  4'h0
`define LCDMD_RST_B1_COUNT  4'hD
`define LCDMD_RST_B2_START  4'h0
`define LCDMD_RST_B2_COUNT  4'h0
`define LCDMD_RST_NLINE     6'h00

`endif

// ---- core/lcdmd_pkg.sv ----
package lcdmd_pkg;

	typedef enum logic {LCDMD_TBL_MAIN, LCDMD_TBL_SUB} lcdmd_tbl_t;

	typedef struct packed {
		lcdmd_tbl_t  tbl;
		logic        disp_on;
		logic        inverse;
		logic        all_on;
		logic        pix_inv;
		logic        pix_on;
		logic        psave;
		logic [3:0]  b1s;
		logic [3:0]  b1c;
		logic [3:0]  b2s;
		logic [3:0]  b2c;
		logic [3:0]  b2_mem;
		logic [6:0]  duty;
		logic [1:0]  nl_hi;
		logic [5:0]  nl_stage;
		logic [5:0]  nline;
	} lcdmd_state_t;

	typedef struct packed {
		logic [3:0] q;
	} lcdmd_mem_state_t;

endpackage : lcdmd_pkg

// ---- core/lcdmd_stage_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lcdmd_cfg.svh"

module lcdmd_stage_mem
(
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        we_i,
	input  wire logic [1:0]  waddr_i,
	input  wire logic [3:0]  wdata_i,
	output logic      [15:0] rdata_o
);
	import lcdmd_pkg::*;

	lcdmd_mem_state_t mem [4];
	lcdmd_mem_state_t next_mem [4];
	logic [15:0]      rdata;

	assign rdata_o = rdata;

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			next_mem[i] = mem[i];
		end
		if (we_i)
		begin
			next_mem[waddr_i].q = wdata_i;
		end
	end

	// ==========================================
	// Staging cells, read data registered
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			mem[0].q <= `LCDMD_RST_B1_START;
			mem[1].q <= `LCDMD_RST_B1_COUNT;
			mem[2].q <= `LCDMD_RST_B2_START;
			mem[3].q <= `LCDMD_RST_B2_COUNT;
			rdata    <= {`LCDMD_RST_B2_COUNT, `LCDMD_RST_B2_START,
				`LCDMD_RST_B1_COUNT, `LCDMD_RST_B1_START};
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				mem[i] <= next_mem[i];
			end
			rdata <= {next_mem[3].q, next_mem[2].q, next_mem[1].q, next_mem[0].q};
		end
	end

endmodule : lcdmd_stage_mem
`default_nettype wire

// ---- core/lcdmd_decoder.sv ----
// Notes on behaviour
// RQ1: Normal/inverse command sets whole-panel polarity from its bit 0.
// RQ2: Polarity command touches no display memory, only output mapping.
// RQ3: Static drive bit 0 forces all pixels on; bit 0 clear restores.
// RQ4: Static all-on wins over inverse polarity.
// RQ5: Static on while display off enters power save.
// RQ6: Byte 0x70 as command in main table selects sub table.
// RQ7: Byte 0x71 in sub table returns to main table.
// RQ8: Host enters sub table before partial, n-line or contrast commands.
// RQ9: Host sends no main-table commands while in sub table.
// RQ10: Thirteen units of eight commons, addressed by index and count.
// RQ11: Executing partial display sets duty to eight times total units.
// RQ12: Block one start 0, count 13 gives 1/104, block two ignored.
// RQ13: Block two start 0, count 0 means no second area.
// RQ14: Sub nibbles 0..3 load block fields; 0x40 executes partial display.
// RQ15: Host sends block fields in fixed order, then execute.
// RQ16: Host keeps block one start at most 12.
// RQ17: Host keeps total units at most 13, blocks not overlapping.
// RQ18: Blocks adjacent on panel, rows from one contiguous memory region.
// RQ19: Partial execute changes duty only, not drive or alternation.
// RQ20: Host should blank display and retune power before partial execute.
// RQ21: Six-bit n-line value; zero is two-frame, k inverts every k+1.
// RQ22: n-line loaded high part then low part, in that order.
// RQ23: Reset restores whole-panel display at 1/104 duty.
// RQ24: Reset clears n-line value to zero.
// RQ25: Partial parameters staged, applied only on execute.
// RQ26: Hardware or command reset selects main table.
`timescale 1ns/10ps
`default_nettype none
`include "lcdmd_cfg.svh"

module lcdmd_decoder
(
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       cmd_valid_i,
	input  wire logic       command_data_select_i,
	input  wire logic [7:0] cmd_byte_i,
	output logic            disp_on_o,
	output logic            pix_invert_o,
	output logic            pix_force_on_o,
	output logic            power_save_o,
	output logic            sub_table_o,
	output logic [3:0]      blk1_start_o,
	output logic [3:0]      blk1_count_o,
	output logic [3:0]      blk2_start_o,
	output logic [3:0]      blk2_count_o,
	output logic [3:0]      blk2_mem_unit_o,
	output logic [6:0]      duty_lines_o,
	output logic [5:0]      nline_o
);
	import lcdmd_pkg::*;

	lcdmd_state_t st;
	lcdmd_state_t next_st;
	logic         cmd;
	logic         mem_we;
	logic [1:0]   mem_waddr;
	logic [15:0]  staged;

	// RQ10: eight commons per unit
	function automatic logic [6:0] units_to_lines(input logic [3:0] u);
		units_to_lines = {u, 3'b000};
	endfunction : units_to_lines

	assign cmd = cmd_valid_i && !command_data_select_i;

	// ==========================================
	// Staging of partial display fields
	// RQ25: stage before execute
	assign mem_we    = cmd && st.tbl == LCDMD_TBL_SUB && cmd_byte_i[7:6] == 2'b00;
	assign mem_waddr = cmd_byte_i[5:4];

	lcdmd_stage_mem lcdmd_stage_mem_inst
	(
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.we_i      (mem_we),
		.waddr_i   (mem_waddr),
		.wdata_i   (cmd_byte_i[3:0]),
		.rdata_o   (staged)
	);

	// ==========================================
	// Command decode
	always_comb
	begin
		next_st = st;
		if (cmd && st.tbl == LCDMD_TBL_MAIN)
		begin
			if (cmd_byte_i == `LCDMD_OP_SUB_ENTER)
			begin
				// RQ6: enter sub table
				next_st.tbl = LCDMD_TBL_SUB;
			end
			else if (cmd_byte_i == `LCDMD_OP_RESET)
			begin
				// RQ23: whole panel again
				next_st.b1s    = `LCDMD_RST_B1_START;
				next_st.b1c    = `LCDMD_RST_B1_COUNT;
				next_st.b2s    = `LCDMD_RST_B2_START;
				next_st.b2c    = `LCDMD_RST_B2_COUNT;
				next_st.b2_mem = `LCDMD_RST_B1_COUNT;
				next_st.duty   = `LCDMD_FULL_LINES;
				// RQ24: two-frame drive
				next_st.nline    = `LCDMD_RST_NLINE;
				next_st.nl_stage = `LCDMD_RST_NLINE;
				next_st.nl_hi    = 2'b00;
				// RQ26: main table after reset
				next_st.tbl = LCDMD_TBL_MAIN;
			end
			else
			begin
				case (cmd_byte_i[7:1])
					`LCDMD_OP_DISP_PFX:
					begin
						next_st.disp_on = cmd_byte_i[0];
					end
					// RQ1: polarity select
					// RQ2: no memory write path
					`LCDMD_OP_INV_PFX:
					begin
						next_st.inverse = cmd_byte_i[0];
					end
					// RQ3: static all-on
					`LCDMD_OP_STAT_PFX:
					begin
						next_st.all_on = cmd_byte_i[0];
					end
					default:
					begin
						next_st.tbl = st.tbl;
					end
				endcase
			end
		end
		else if (cmd)
		begin
			// RQ14: sub table decode
			case (cmd_byte_i[7:4])
				4'h4:
				begin
					if (cmd_byte_i == `LCDMD_SUB_PART_EXEC)
					begin
						// RQ25: apply staged fields
						next_st.b1s = staged[3:0];
						next_st.b1c = staged[7:4];
						// RQ12: full panel drops block two
						if (staged[3:0] == 4'h0 && staged[7:4] == `LCDMD_UNITS)
						begin
							next_st.b2s = 4'h0;
							next_st.b2c = 4'h0;
						end
						else
						begin
							// RQ13: zero count means one block
							next_st.b2s = staged[11:8];
							next_st.b2c = staged[15:12];
						end
						// RQ18: block two rows follow block one
						next_st.b2_mem = 4'(staged[3:0] + staged[7:4]);
						// RQ11: duty from total units
						// RQ19: only duty changes
						next_st.duty = units_to_lines(4'(next_st.b1c + next_st.b2c));
					end
				end
				// RQ22: high part first
				`LCDMD_SUB_NL_HI:
				begin
					next_st.nl_hi = cmd_byte_i[1:0];
				end
				`LCDMD_SUB_NL_LO:
				begin
					next_st.nl_stage = {st.nl_hi, cmd_byte_i[3:0]};
				end
				4'h7:
				begin
					if (cmd_byte_i == `LCDMD_SUB_NL_EXEC)
					begin
						// RQ21: apply inverse line value
						next_st.nline = st.nl_stage;
					end
					else if (cmd_byte_i == `LCDMD_SUB_EXIT)
					begin
						// RQ7: back to main table
						next_st.tbl = LCDMD_TBL_MAIN;
					end
				end
				default:
				begin
					next_st.tbl = st.tbl;
				end
			endcase
		end
		// RQ4: all-on overrides inverse
		next_st.pix_on  = next_st.all_on;
		next_st.pix_inv = next_st.inverse && !next_st.all_on;
		// RQ5: static on with display off
		next_st.psave = next_st.all_on && !next_st.disp_on;
	end

	// ==========================================
	// State register
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st          <= '0;
			st.tbl      <= LCDMD_TBL_MAIN;
			st.b1s      <= `LCDMD_RST_B1_START;
			st.b1c      <= `LCDMD_RST_B1_COUNT;
			st.b2s      <= `LCDMD_RST_B2_START;
			st.b2c      <= `LCDMD_RST_B2_COUNT;
			st.b2_mem   <= `LCDMD_RST_B1_COUNT;
			st.duty     <= `LCDMD_FULL_LINES;
			st.nline    <= `LCDMD_RST_NLINE;
			st.nl_stage <= `LCDMD_RST_NLINE;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign disp_on_o       = st.disp_on;
	assign pix_invert_o    = st.pix_inv;
	assign pix_force_on_o  = st.pix_on;
	assign power_save_o    = st.psave;
	assign sub_table_o     = logic'(st.tbl);
	assign blk1_start_o    = st.b1s;
	assign blk1_count_o    = st.b1c;
	assign blk2_start_o    = st.b2s;
	assign blk2_count_o    = st.b2c;
	assign blk2_mem_unit_o = st.b2_mem;
	assign duty_lines_o    = st.duty;
	assign nline_o         = st.nline;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	logic main_cmd;
	logic sub_cmd;
	assign main_cmd = cmd && !sub_table_o;
	assign sub_cmd  = cmd && sub_table_o;

	// RQ1: polarity follows bit 0
	AST_INV_SET: assert property (main_cmd && cmd_byte_i[7:1] == `LCDMD_OP_INV_PFX
		&& !st.all_on |=> pix_invert_o == $past(cmd_byte_i[0]))
		else $error("inverse polarity not applied"); // RQ1

	// RQ2: polarity leaves mapping alone
	AST_INV_KEEP: assert property (main_cmd && cmd_byte_i[7:1] == `LCDMD_OP_INV_PFX
		|=> $stable(duty_lines_o) && $stable(blk2_mem_unit_o))
		else $error("inverse changed display mapping"); // RQ2

	// RQ3: static drive follows bit 0
	AST_STATIC: assert property (main_cmd && cmd_byte_i[7:1] == `LCDMD_OP_STAT_PFX
		|=> pix_force_on_o == $past(cmd_byte_i[0]))
		else $error("static drive not applied"); // RQ3

	// RQ4: all-on has priority
	AST_PRIO: assert property (pix_force_on_o |-> !pix_invert_o)
		else $error("inverse active under all-on"); // RQ4

	// RQ5: power save entry
	AST_PSAVE: assert property (main_cmd && cmd_byte_i == {`LCDMD_OP_STAT_PFX, 1'b1}
		&& !disp_on_o |=> power_save_o)
		else $error("power save not entered"); // RQ5

	// RQ6: sub table entry
	AST_SUB_IN: assert property (main_cmd && cmd_byte_i == `LCDMD_OP_SUB_ENTER
		|=> sub_table_o)
		else $error("sub table not entered"); // RQ6

	// RQ7: sub table exit
	AST_SUB_OUT: assert property (sub_cmd && cmd_byte_i == `LCDMD_SUB_EXIT
		|=> !sub_table_o)
		else $error("sub table not left"); // RQ7

	// RQ11: duty tracks units
	AST_DUTY: assert property (sub_cmd && cmd_byte_i == `LCDMD_SUB_PART_EXEC
		|=> duty_lines_o == units_to_lines(4'(blk1_count_o + blk2_count_o)))
		else $error("duty not eight per unit"); // RQ11

	// RQ12: full panel ignores block two
	AST_FULL: assert property (blk1_start_o == 4'h0 && blk1_count_o == `LCDMD_UNITS
		|-> blk2_count_o == 4'h0 && duty_lines_o == `LCDMD_FULL_LINES)
		else $error("full panel not 1/104"); // RQ12

	// RQ22: low part then execute
	AST_NLINE: assert property (sub_cmd && cmd_byte_i[7:4] == `LCDMD_SUB_NL_LO
		##1 sub_cmd && cmd_byte_i == `LCDMD_SUB_NL_EXEC
		|=> nline_o[3:0] == $past(cmd_byte_i[3:0], 2))
		else $error("n-line low part lost"); // RQ22

	// RQ23: reset command defaults
	AST_RST_CMD: assert property (main_cmd && cmd_byte_i == `LCDMD_OP_RESET
		|=> duty_lines_o == `LCDMD_FULL_LINES && nline_o == 6'h00 && !sub_table_o)
		else $error("reset command defaults wrong"); // RQ23

	COV_PART: cover property (sub_cmd && cmd_byte_i == `LCDMD_SUB_PART_EXEC
		##1 duty_lines_o != `LCDMD_FULL_LINES);
	COV_PSAVE: cover property (power_save_o);
	COV_NLINE: cover property (nline_o != 6'h00 ##1 !sub_table_o);

endmodule : lcdmd_decoder
`default_nettype wire

// ---- sim/lcdmd_host.sv ----
`timescale 1ns/10ps
`default_nettype none

module lcdmd_host
(
	input  wire logic       clk_i,
	output logic            cmd_valid_o,
	output logic            command_data_select_o,
	output logic [7:0]      cmd_byte_o
);
	// ========================================
	// Idle bus
	initial
	begin
		cmd_valid_o = 1'b0;
		command_data_select_o = 1'b1;
		cmd_byte_o = 8'h00;
	end

	// ========================================
	// One write cycle
	// order and values chosen by caller
	task automatic put(input logic sel, input logic [7:0] b);
		begin
			@(posedge clk_i);
			#1;
			cmd_valid_o = 1'b1;
			command_data_select_o = sel;
			cmd_byte_o = b;
			@(posedge clk_i);
			#1;
			cmd_valid_o = 1'b0;
			command_data_select_o = 1'b1;
			// Released bus shows no stale byte
			cmd_byte_o = ~b;
		end
	endtask : put

	// ========================================
	// Two bytes back to back, strobe held up
	task automatic put_pair(input logic sel, input logic [7:0] b0, input logic [7:0] b1);
		begin
			@(posedge clk_i);
			#1;
			cmd_valid_o = 1'b1;
			command_data_select_o = sel;
			cmd_byte_o = b0;
			@(posedge clk_i);
			#1;
			cmd_byte_o = b1;
			@(posedge clk_i);
			#1;
			cmd_valid_o = 1'b0;
			command_data_select_o = 1'b1;
			cmd_byte_o = ~b1;
		end
	endtask : put_pair
endmodule : lcdmd_host

`default_nettype wire

// ---- sim/lcdmd_decoder_bench.sv ----
`timescale 1ns/10ps
`default_nettype none

module lcdmd_decoder_bench;
	logic       clk_i;
	logic       sys_rst_i;
	logic       cmd_valid;
	logic       sel;
	logic [7:0] cmd_byte;
	logic       disp_on, pix_inv, force_on, psave, sub_tbl;
	logic [3:0] b1s, b1c, b2s, b2c, b2m;
	logic [6:0] duty;
	logic [5:0] nline;
	int         n_fail = 0;
	int         samples_checked = 0;

	lcdmd_host lcdmd_host_inst (.clk_i(clk_i), .cmd_valid_o(cmd_valid),
		.command_data_select_o(sel), .cmd_byte_o(cmd_byte));

	lcdmd_decoder lcdmd_decoder_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.cmd_valid_i(cmd_valid), .command_data_select_i(sel), .cmd_byte_i(cmd_byte),
		.disp_on_o(disp_on), .pix_invert_o(pix_inv), .pix_force_on_o(force_on),
		.power_save_o(psave), .sub_table_o(sub_tbl), .blk1_start_o(b1s),
		.blk1_count_o(b1c), .blk2_start_o(b2s), .blk2_count_o(b2c),
		.blk2_mem_unit_o(b2m), .duty_lines_o(duty), .nline_o(nline));

	// ========================================
	// Clock and watchdog
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Whole run is well under 200 cycles
	initial
	begin
		#(20 * 2000);
		n_fail++;
		final_report();
	end

	// ========================================
	// Helpers
	task automatic final_report;
		begin
			if (n_fail == 0 && samples_checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask : final_report

	task automatic chk(input logic [6:0] got, input logic [6:0] exp);
		begin
			samples_checked++;
			if (got !== exp)
			begin
				n_fail++;
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask : chk

	task automatic cmd(input logic [7:0] b);
		lcdmd_host_inst.put(1'b0, b);
	endtask : cmd

	task automatic fields(input logic [3:0] a, b, c, d);
		begin
			cmd({4'h0, a});
			cmd({4'h1, b});
			cmd({4'h2, c});
			cmd({4'h3, d});
		end
	endtask : fields

	task automatic hw_reset;
		begin
			@(posedge clk_i);
			#1;
			sys_rst_i = 1'b1;
			repeat (3) @(posedge clk_i);
			#1;
			sys_rst_i = 1'b0;
		end
	endtask : hw_reset

	task automatic chk_panel(input logic [3:0] s1, c1, s2, c2, m, input logic [6:0] d);
		begin
			chk({3'h0, b1s}, {3'h0, s1});
			chk({3'h0, b1c}, {3'h0, c1});
			chk({3'h0, b2s}, {3'h0, s2});
			chk({3'h0, b2c}, {3'h0, c2});
			chk({3'h0, b2m}, {3'h0, m});
			chk(duty, d);
		end
	endtask : chk_panel

	// ========================================
	// Scenarios
	task automatic t_reset;
		begin
			chk_panel(4'h0, 4'hD, 4'h0, 4'h0, 4'hD, 7'h68);
			chk({1'b0, nline}, 7'h00);
			chk({6'h00, sub_tbl}, 7'h00);
			chk({3'h0, disp_on, pix_inv, force_on, psave}, 7'h00);
		end
	endtask : t_reset

	task automatic t_main;
		begin
			cmd(8'hA7);
			chk({6'h00, pix_inv}, 7'h01);
			cmd(8'hA5);
			chk({6'h00, force_on}, 7'h01);
			chk({6'h00, pix_inv}, 7'h00);
			chk({6'h00, psave}, 7'h01);
			lcdmd_host_inst.put(1'b1, 8'hA4);
			chk({6'h00, force_on}, 7'h01);
			cmd(8'hA4);
			chk({4'h0, force_on, pix_inv, psave}, 7'h02);
			cmd(8'hAF);
			cmd(8'hA5);
			chk({4'h0, disp_on, force_on, psave}, 7'h06);
			cmd(8'hA4);
			cmd(8'hA6);
			chk({5'h00, force_on, pix_inv}, 7'h00);
			chk(duty, 7'h68);
		end
	endtask : t_main

	task automatic t_partial;
		begin
			cmd(8'hAE);
			cmd(8'h70);
			chk({6'h00, sub_tbl}, 7'h01);
			fields(4'h0, 4'h2, 4'h4, 4'h5);
			chk_panel(4'h0, 4'hD, 4'h0, 4'h0, 4'hD, 7'h68);
			cmd(8'h40);
			chk_panel(4'h0, 4'h2, 4'h4, 4'h5, 4'h2, 7'h38);
			chk({disp_on, nline}, 7'h00);
		end
	endtask : t_partial

	task automatic t_full;
		begin
			fields(4'h0, 4'hD, 4'h0, 4'h0);
			cmd(8'h40);
			chk_panel(4'h0, 4'hD, 4'h0, 4'h0, 4'hD, 7'h68);
			cmd(8'h03);
			cmd(8'h14);
			cmd(8'h20);
			lcdmd_host_inst.put_pair(1'b0, 8'h30, 8'h40);
			chk_panel(4'h3, 4'h4, 4'h0, 4'h0, 4'h7, 7'h20);
		end
	endtask : t_full

	task automatic t_nline;
		begin
			cmd(8'h51);
			cmd(8'h63);
			chk({1'b0, nline}, 7'h00);
			cmd(8'h70);
			chk({1'b0, nline}, 7'h13);
			cmd(8'h53);
			lcdmd_host_inst.put_pair(1'b0, 8'h6F, 8'h70);
			chk({1'b0, nline}, 7'h3F);
			cmd(8'h71);
			chk({6'h00, sub_tbl}, 7'h00);
			cmd(8'hAF);
			cmd(8'hE2);
			chk({1'b0, nline}, 7'h00);
			chk_panel(4'h0, 4'hD, 4'h0, 4'h0, 4'hD, 7'h68);
			chk({5'h00, sub_tbl, disp_on}, 7'h01);
		end
	endtask : t_nline

	task automatic t_hw_reset;
		begin
			cmd(8'h70);
			hw_reset();
			chk({5'h00, sub_tbl, disp_on}, 7'h00);
		end
	endtask : t_hw_reset

	// ========================================
	// Main sequence
	initial
	begin
		sys_rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		t_reset();
		t_main();
		t_partial();
		t_full();
		t_nline();
		t_hw_reset();
		final_report();
	end
endmodule : lcdmd_decoder_bench

`default_nettype wire
